// ==== hdl/ioaoc_pkg.sv ====
// Purpose: shared types and constants for the i/o access ordering control block
// Assumes: one core clock, requests arrive one at a time from the core side
// Notes: attribute codes travel with each bus request
// Behaviour
// - cacheable read hits may bypass buffered writes
// - uncacheable accesses issue in program order
// - serializing op drains all earlier accesses first
// - port writes never enter write buffer
// - port read waits for pending stores
// - port write blocks next until complete
package ioaoc_pkg;

  // access attribute driven with every external bus request
  typedef enum logic [1:0] {
    IOAOC_ATTR_CACHE   = 2'h0,  // cacheable memory
    IOAOC_ATTR_UNCACHE = 2'h1,  // uncacheable memory
    IOAOC_ATTR_PORT    = 2'h2   // port address space
  } ioaoc_attr_t;

  // operation class presented by the core
  typedef enum logic [2:0] {
    IOAOC_OP_MEM_RD    = 3'h0,  // memory read
    IOAOC_OP_MEM_WR    = 3'h1,  // memory write
    IOAOC_OP_PORT_RD   = 3'h2,  // single, block or block_prefix port load
    IOAOC_OP_PORT_WR   = 3'h3,  // single, block or block_prefix port store
    IOAOC_OP_SERIALIZE = 3'h4   // serializing operation
  } ioaoc_op_t;

  // request from the core
  typedef struct packed {
    ioaoc_op_t   op;            // operation class
    logic        cacheable;     // target region is cacheable
    logic [31:0] addr;          // target address
    logic [31:0] data;          // write data
  } ioaoc_req_t;

  // request on the external bus
  typedef struct packed {
    ioaoc_attr_t attr;          // ordering and buffering attribute
    logic        write;         // write when set
    logic [31:0] addr;          // target address
    logic [31:0] data;          // write data
  } ioaoc_bus_t;

  localparam int unsigned IOAOC_WB_DEPTH = 4;      // write buffer entries
  localparam logic [2:0]  IOAOC_CNT_RST  = 3'h0;   // occupancy after reset

endpackage : ioaoc_pkg

// ==== hdl/ioaoc_top.sv ====
// Purpose: order core memory and port accesses onto the external bus
// Assumes: bus_done pulses once per accepted bus request, in order
// Notes: cacheable read hits are answered internally, never wait on the buffer
`timescale 1ns/10ps
module ioaoc_top #(
  parameter int unsigned DEPTH = ioaoc_pkg::IOAOC_WB_DEPTH  // write buffer entries
) (
  input  wire logic                 ref_clk,      // core clock, 100 MHz
  input  wire logic                 reset_n,      // async active-low reset
  input  wire ioaoc_pkg::ioaoc_req_t req,         // core request
  input  wire logic                 req_valid,    // core request present
  output wire logic                 req_ready,    // core request accepted
  input  wire logic                 hit,          // cacheable read hit in cache
  output logic                      hit_done,     // read served internally
  output ioaoc_pkg::ioaoc_bus_t     bus_req,      // external bus request
  output logic                      bus_valid,    // bus request present
  input  wire logic                 bus_ready,    // bus accepts request
  input  wire logic                 bus_done,     // bus completes oldest request
  output logic                      stall         // core held off by ordering
);

  // reset release through two flops
  logic rst_s1_q;  // first stage, read only by the second
  logic rst_n_q;   // released reset used by all other logic
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // pointer width; depth is taken as a power of two so the pointers wrap freely
  localparam int AW = $clog2(DEPTH);

  // write buffer for cacheable/uncacheable memory writes
  ioaoc_pkg::ioaoc_bus_t wb_q [DEPTH];     // buffered writes
  logic [AW-1:0]         wr_ptr_q, rd_ptr_q; // buffer pointers
  logic [AW:0]           wb_cnt_q;         // buffer occupancy
  logic [3:0]            out_q;            // issued, not yet completed
  logic                  pwr_wait_q;       // port write in flight

  // classify the incoming request
  wire logic is_mrd   = req.op == ioaoc_pkg::IOAOC_OP_MEM_RD;
  wire logic is_mwr   = req.op == ioaoc_pkg::IOAOC_OP_MEM_WR;
  wire logic is_prd   = req.op == ioaoc_pkg::IOAOC_OP_PORT_RD;
  wire logic is_pwr   = req.op == ioaoc_pkg::IOAOC_OP_PORT_WR;
  wire logic is_ser   = req.op == ioaoc_pkg::IOAOC_OP_SERIALIZE;
  wire logic wb_empty = wb_cnt_q == '0;
  wire logic wb_full  = wb_cnt_q == (AW+1)'(DEPTH);
  wire logic drained  = wb_empty && (out_q == 4'h0) && !bus_valid;

  // cacheable read hit bypasses buffered writes
  wire logic fast_rd  = is_mrd && req.cacheable && hit;
  // port reads, serializing ops and uncacheable memory accesses must wait for all older traffic
  wire logic need_drain = is_prd || is_ser || (!req.cacheable && (is_mrd || is_mwr));
  wire logic direct   = is_prd || is_pwr || (is_mrd && !fast_rd);
  wire logic ok_mwr   = is_mwr && !wb_full && (req.cacheable || drained);
  wire logic ok_dir   = direct && !bus_valid && (need_drain ? drained : wb_empty);
  wire logic blocked  = pwr_wait_q;
  wire logic take     = req_valid && !blocked &&
                        (fast_rd || ok_mwr || ok_dir || (is_ser && drained));

  // ready is combinational so a request is taken in the cycle it becomes legal
  assign req_ready = take;

  // attribute of a core request
  function automatic ioaoc_pkg::ioaoc_attr_t attr_of(input ioaoc_pkg::ioaoc_req_t r);
    if (r.op == ioaoc_pkg::IOAOC_OP_PORT_RD || r.op == ioaoc_pkg::IOAOC_OP_PORT_WR)
      return ioaoc_pkg::IOAOC_ATTR_PORT;
    return r.cacheable ? ioaoc_pkg::IOAOC_ATTR_CACHE : ioaoc_pkg::IOAOC_ATTR_UNCACHE;
  endfunction

  wire ioaoc_pkg::ioaoc_bus_t cur = '{attr: attr_of(req), write: is_mwr || is_pwr,
                                      addr: req.addr, data: req.data};
  wire logic issue   = bus_valid && bus_ready;
  wire logic wb_push = take && is_mwr;
  // buffer drains only into an idle bus slot; direct ops need an empty buffer anyway
  wire logic wb_pop  = !bus_valid && !wb_empty && !(take && direct);

  // bus request register: direct ops win only when buffer is empty
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_valid <= 1'b0;
      bus_req   <= '0;
    end else if (take && direct) begin
      bus_valid <= 1'b1;
      bus_req   <= cur;
    end else if (wb_pop) begin
      bus_valid <= 1'b1;
      bus_req   <= wb_q[rd_ptr_q]; // oldest write goes first, in order
    end else if (issue) begin
      bus_valid <= 1'b0;
    end
  end

  // write buffer storage and pointers
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      wb_cnt_q <= (AW+1)'(ioaoc_pkg::IOAOC_CNT_RST);
      for (int i = 0; i < DEPTH; i++) wb_q[i] <= '0;
    end else begin
      if (wb_push) begin
        wb_q[wr_ptr_q] <= cur;
        wr_ptr_q       <= wr_ptr_q + 1'b1;
      end
      if (wb_pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      wb_cnt_q <= wb_cnt_q + (AW+1)'(wb_push) - (AW+1)'(wb_pop);
    end
  end

  // outstanding count; chipset posting is outside our view, so done means bus done only
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_q <= 4'h0;
    end else begin
      out_q <= out_q + 4'(issue) - 4'(bus_done && out_q != 4'h0);
    end
  end

  // port write holds the next op until its own completion and all older stores
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pwr_wait_q <= 1'b0;
    end else if (take && is_pwr) begin
      pwr_wait_q <= 1'b1;
    end else if (pwr_wait_q && drained) begin
      pwr_wait_q <= 1'b0;
    end
  end

  // completion and stall indications
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hit_done <= 1'b0;
      stall    <= 1'b0;
    end else begin
      hit_done <= take && fast_rd;
      stall    <= req_valid && !take;
    end
  end

  // all checks share the core clock and the released reset
  default clocking ast_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_q);

  // a port store accepted from the core
  sequence s_pwr_take;
    take && is_pwr;
  endsequence
  // a port load accepted from the core
  sequence s_prd_take;
    take && is_prd;
  endsequence
  // port store standing on the external bus
  sequence s_pwr_on_bus;
    bus_valid && bus_req.write && bus_req.attr == ioaoc_pkg::IOAOC_ATTR_PORT;
  endsequence
  // port load standing on the external bus
  sequence s_prd_on_bus;
    bus_valid && !bus_req.write && bus_req.attr == ioaoc_pkg::IOAOC_ATTR_PORT;
  endsequence
  // cacheable read hit accepted from the core
  sequence s_hit_take;
    take && fast_rd;
  endsequence
  // bus request still waiting to be accepted
  sequence s_bus_wait;
    bus_valid && !bus_ready;
  endsequence

  // anything pushed into the buffer must be memory traffic
  AST_PWR_NO_BUF: assert property (
    wb_push |-> cur.attr != ioaoc_pkg::IOAOC_ATTR_PORT)
    else $error("port write pushed into write buffer");
  // a port store goes straight onto the bus in the next cycle
  AST_PWR_ISSUE: assert property (
    s_pwr_take |=> s_pwr_on_bus)
    else $error("port write did not go straight to the bus");
  // port load waits until every older store has completed
  AST_PRD_DRAIN: assert property (
    s_prd_take |-> wb_empty && out_q == 4'h0 && !bus_valid)
    else $error("port read issued with stores pending");
  // nothing is taken in the three cycles after a port store is taken
  AST_PWR_BLOCK: assert property (
    s_pwr_take |=> (!take)[*3])
    else $error("op taken right behind a port write");
  // the hold lasts until the port store and older stores are done
  AST_PWR_HOLD: assert property (
    (pwr_wait_q && !drained) |-> !take)
    else $error("op taken behind unfinished port write");
  // uncacheable memory traffic never overtakes anything older
  AST_UC_ORDER: assert property (
    (take && !req.cacheable && !is_prd && !is_pwr && !is_ser) |-> drained)
    else $error("uncacheable access passed older traffic");
  // a held bus request keeps its contents until accepted
  AST_BUS_HOLD: assert property (
    s_bus_wait |=> bus_valid && $stable(bus_req))
    else $error("bus request changed before it was accepted");
  // serializing op only completes once everything older is done
  AST_SER: assert property (
    (take && is_ser) |-> drained)
    else $error("serializing op before drain");
  // a cacheable hit is never held behind buffered writes
  AST_HIT: assert property (
    (req_valid && fast_rd && !blocked) |-> s_hit_take ##1 hit_done)
    else $error("cacheable hit was held behind writes");
  // buffer occupancy never runs past its depth
  AST_WB_BOUND: assert property (
    wb_cnt_q <= (AW+1)'(DEPTH))
    else $error("write buffer occupancy beyond depth");
  // a port load carries the port attribute on the bus
  AST_ATTR: assert property (
    s_prd_take |=> s_prd_on_bus)
    else $error("port request lacks port attribute");
  // one completion retires the last outstanding request
  AST_OUT: assert property (
    (bus_done && out_q == 4'h1 && !issue) |=> out_q == 4'h0)
    else $error("outstanding count did not retire");

endmodule // ioaoc_top

// ==== test/ioaoc_bus_model.sv ====
// Purpose: far-side bus and chipset model for the ordering block
// Assumes: completions return in acceptance order
// Notes: slow mode halves ready and stretches completion
`timescale 1ns/10ps
module ioaoc_bus_model (
  input  wire logic ref_clk,    // core clock
  input  wire logic reset_n,    // async active-low reset
  input  wire logic bus_valid,  // request present
  input  wire logic slow,       // stall mode from the bench
  output logic      bus_ready,  // request accepted
  output logic      bus_done    // oldest request complete
);
  logic [3:0] pend_q;  // accepted, not yet completed
  logic [1:0] tmr_q;   // completion latency counter
  wire        acc  = bus_valid && bus_ready;
  // posting is invisible here, so a completion is all the core ever sees
  wire        fin  = (pend_q != 4'h0) && (!slow || tmr_q == 2'h3);
  // ready toggles when slow so the design must hold its request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ready <= 1'b0;
      bus_done  <= 1'b0;
      pend_q    <= 4'h0;
      tmr_q     <= 2'h0;
    end else begin
      bus_ready <= !slow || !bus_ready;
      bus_done  <= fin;
      pend_q    <= pend_q + {3'h0, acc} - {3'h0, fin};
      tmr_q     <= fin ? 2'h0 : tmr_q + 2'h1;
    end
  end
endmodule // ioaoc_bus_model

// ==== test/test_io_access_ordering_control.sv ====
// Purpose: self-checking bench for the ordering block
// Assumes: random core traffic, bus model with random stalls
// Notes: expected bus order is program order of bus-going requests
`timescale 1ns/10ps
module test_io_access_ordering_control;
  logic                  ref_clk = 0, reset_n = 0, req_valid = 0, hit = 0, slow = 0;
  logic                  req_ready, hit_done, bus_valid, bus_ready, bus_done, stall;
  ioaoc_pkg::ioaoc_req_t req = '0;  // core request
  ioaoc_pkg::ioaoc_bus_t bus_req;   // issued request
  ioaoc_pkg::ioaoc_bus_t expq[$];   // expected bus order
  int miscompares = 0, n_checks = 0, cyc = 0, outst = 0;
  logic took = 0, run = 0, hit_e = 0, stall_e = 0, pw_open = 0;
  ioaoc_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .hit(hit), .hit_done(hit_done), .bus_req(bus_req),
    .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_done(bus_done), .stall(stall));
  ioaoc_bus_model FAR (.ref_clk(ref_clk), .reset_n(reset_n), .bus_valid(bus_valid),
    .slow(slow), .bus_ready(bus_ready), .bus_done(bus_done));
  initial forever #5 ref_clk = !ref_clk;
  task automatic chk(string n, logic [66:0] e, logic [66:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cycle ceiling: a hang counts as a mismatch and goes to the report
  always @(posedge ref_clk) if (run) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  // reference model: queue of bus-going requests, outstanding count
  always @(posedge ref_clk) if (run) begin
    ioaoc_pkg::ioaoc_bus_t e;
    chk("hit_done", hit_e, hit_done);
    chk("stall", stall_e, stall);
    hit_e = 0;
    stall_e = req_valid && !req_ready;
    if (bus_done) outst--;
    if (bus_valid && bus_ready) begin
      e = (expq.size() > 0) ? expq.pop_front() : '1;
      chk("bus_req", {e.attr, e.write, e.addr, e.write ? e.data : 32'h0},
        {bus_req.attr, bus_req.write, bus_req.addr, bus_req.write ? bus_req.data : 32'h0});
      outst++;
    end
    if (expq.size() == 0 && outst == 0) pw_open = 0;
    if (req_valid && req_ready) begin
      took = 1;
      chk("port_wr_wait", 0, pw_open);
      if (req.op inside {ioaoc_pkg::IOAOC_OP_SERIALIZE, ioaoc_pkg::IOAOC_OP_PORT_RD} ||
          (!req.cacheable && req.op inside {ioaoc_pkg::IOAOC_OP_MEM_RD,
                                            ioaoc_pkg::IOAOC_OP_MEM_WR}))
        chk("drain", 0, expq.size() + outst);
      if (req.op == ioaoc_pkg::IOAOC_OP_MEM_RD && req.cacheable && hit) hit_e = 1;
      else if (req.op != ioaoc_pkg::IOAOC_OP_SERIALIZE) begin
        e.attr  = (req.op inside {ioaoc_pkg::IOAOC_OP_PORT_RD, ioaoc_pkg::IOAOC_OP_PORT_WR}) ?
          ioaoc_pkg::IOAOC_ATTR_PORT : req.cacheable ? ioaoc_pkg::IOAOC_ATTR_CACHE :
          ioaoc_pkg::IOAOC_ATTR_UNCACHE;
        e.write = req.op inside {ioaoc_pkg::IOAOC_OP_MEM_WR, ioaoc_pkg::IOAOC_OP_PORT_WR};
        e.addr  = req.addr;
        e.data  = req.data;
        expq.push_back(e);
      end
      if (req.op == ioaoc_pkg::IOAOC_OP_PORT_WR) pw_open = 1;
    end
  end
  // drive at falling edges; request held until the monitor sees it taken
  task automatic send(ioaoc_pkg::ioaoc_req_t r, logic h);
    req = r;
    hit = h;
    req_valid = 1;
    took = 0;
    while (!took) @(negedge ref_clk);
  endtask
  initial begin
    ioaoc_pkg::ioaoc_req_t r;
    void'($urandom(32'h2fdf));
    repeat (3) @(negedge ref_clk);
    reset_n = 1;
    repeat (3) @(negedge ref_clk);
    run = 1;
    // random mix: 300 requests, op, cacheability, hit and slow mode drawn at random per request
    for (int i = 0; i < 300; i++) begin
      r.op = ioaoc_pkg::ioaoc_op_t'(3'($urandom % 5));
      r.cacheable = 1'($urandom);
      r.addr = $urandom;
      r.data = $urandom;
      slow = 1'($urandom);
      send(r, 1'($urandom));
    end
    req_valid = 0;
    while (expq.size() > 0 || outst > 0) @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
    summarize();
  end
endmodule // test_io_access_ordering_control
